// ===== verilog/mbp_port.sv
// Eight-bit pin-shared bidirectional port with priority ownership
// Summary of operation
// - Eight pins, one per latch/direction bit
// - Direction 0 drives latch, 1 inputs
// - Port reads use Schmitt input path on inputs, latch on outputs
// - Reset leaves every pin an input
// - Port usable only when bus disabled or on the smaller package
// - Memory bus drives address/data, ignores direction
// - Memory bus samples via TTL buffer
// - Parallel port owns pins when selected and active
// - Parallel port overrides direction, TTL inputs
// - One control bit enables the pull-ups
// - Pull-up off while pin is output
// - Reset leaves pull-ups disabled
// - SPI data out on pin 4
// - SPI data in from pin 5
// - I2C data drives pin 5, own threshold
// - Memory bus only on larger package
// - Pull-up bit reads back as written on either package
`include "mbp_cfg.svh"
module mbp_port #(
   parameter bit LARGE_PKG = 1'b1 // Larger package with memory bus
) (
   input wire logic REF_CLK_IN, // 40 MHz clock
   input wire logic RSTN_IN, // Async reset, active low
   input wire logic LAT_WE_IN, // Output latch write strobe
   input wire logic [7:0] LAT_D_IN, // Output latch write data
   input wire logic DIR_WE_IN, // Direction write strobe
   input wire logic [7:0] DIR_D_IN, // Direction write data
   input wire logic PU_WE_IN, // Pull-up control write strobe
   input wire logic PU_D_IN, // Pull-up control write data
   input wire logic EXT_BUS_DISABLE_IN, // Memory bus disable bit
   input wire logic EXT_OE_IN, // Memory bus drives pins
   input wire mbp_pkg::mbp_byte_t EXT_AD_IN, // Memory bus address/data out
   input wire logic PAR_SEL_IN, // Parallel port pin select
   input wire logic PAR_ACTIVE_IN, // Parallel port active
   input wire logic PAR_OE_IN, // Parallel port drives pins
   input wire mbp_pkg::mbp_byte_t PAR_D_IN, // Parallel port data out
   input wire logic SER_SPI_IN, // Serial module in SPI mode
   input wire logic SER_I2C_IN, // Serial module in I2C mode
   input wire logic SER_SDO_IN, // SPI serial data out
   input wire logic SER_SDA_OE_IN, // I2C data pulls low
   input wire logic SER_SMB_LVL_IN, // I2C uses TTL level when high
   input wire mbp_pkg::mbp_byte_t PIN_IN, // Pin levels
   output mbp_pkg::mbp_byte_t PIN_OUT, // Pin drive value
   output mbp_pkg::mbp_byte_t PIN_OE_OUT, // Pin drive enable
   output mbp_pkg::mbp_byte_t PULLUP_EN_OUT, // Weak pull-up enables
   output mbp_pkg::mbp_byte_t PORT_VAL_OUT, // Port read value
   output mbp_pkg::mbp_byte_t LAT_OUT, // Output latch readback
   output mbp_pkg::mbp_byte_t DIR_OUT, // Direction readback
   output logic PU_CTRL_OUT, // Pull-up control readback
   output mbp_pkg::mbp_byte_t EXT_AD_OUT, // Memory bus data in (TTL)
   output mbp_pkg::mbp_byte_t PAR_D_OUT, // Parallel port data in (TTL)
   output logic SER_SDI_OUT, // SPI data in
   output logic SER_SDA_OUT, // I2C data in
   output mbp_pkg::mbp_owner_t OWNER_OUT // Current pin owner
);
   import mbp_pkg::*;

   mbp_byte_t lat;
   mbp_byte_t dir;
   logic pu_ctrl;
   mbp_byte_t pin_sync;
   mbp_byte_t pin_q;
   mbp_byte_t port_val;
   mbp_byte_t ext_in;
   mbp_byte_t par_in;
   logic sdi;
   logic sda;

   mbp_regs u_regs (
      .clk_in(REF_CLK_IN),
      .rstn_in(RSTN_IN),
      .lat_we_in(LAT_WE_IN),
      .lat_d_in(LAT_D_IN),
      .dir_we_in(DIR_WE_IN),
      .dir_d_in(DIR_D_IN),
      .pu_we_in(PU_WE_IN),
      .pu_d_in(PU_D_IN),
      .lat_out(lat),
      .dir_out(dir),
      .pu_out(pu_ctrl)
   );

   mbp_sync u_sync (
      .clk_in(REF_CLK_IN),
      .rstn_in(RSTN_IN),
      .d_in(PIN_IN),
      .q_out(pin_sync)
   );
   // The input buffer type is analog; digitally both views share the filtered level
   assign pin_q = pin_sync;

   wire ext_own = LARGE_PKG && !EXT_BUS_DISABLE_IN;
   wire par_own = !ext_own && PAR_SEL_IN && PAR_ACTIVE_IN;
   wire ser_spi = !ext_own && !par_own && SER_SPI_IN;
   wire ser_i2c = !ext_own && !par_own && SER_I2C_IN && !SER_SPI_IN;

   mbp_owner_t owner;
   assign owner = ext_own ? MBP_OWN_EXT :
                  par_own ? MBP_OWN_PAR :
                  (ser_spi || ser_i2c) ? MBP_OWN_SER : MBP_OWN_GPIO;

   wire [7:0] gp_oe = ~dir;
   wire [7:0] gp_o = lat;
   // SPI data out takes pin 4 from the latch
   wire sdo_take = ser_spi && !dir[`MBP_SDO_PIN];
   // I2C open-drain data on pin 5
   wire sda_take = ser_i2c && dir[`MBP_SDA_PIN];

   function automatic mbp_byte_t set_bit(input mbp_byte_t v, input int idx, input logic b);
      mbp_byte_t r;
      r = v;
      r[idx] = b;
      return r;
   endfunction

   wire [7:0] ser_o_a = sdo_take ? set_bit(gp_o, `MBP_SDO_PIN, SER_SDO_IN) : gp_o;
   wire [7:0] ser_o = sda_take ? set_bit(ser_o_a, `MBP_SDA_PIN, 1'b0) : ser_o_a;
   wire [7:0] ser_oe = sda_take ? set_bit(gp_oe, `MBP_SDA_PIN, SER_SDA_OE_IN) : gp_oe;

   wire [7:0] next_o = ext_own ? EXT_AD_IN : par_own ? PAR_D_IN : ser_o;
   wire [7:0] next_oe = ext_own ? {8{EXT_OE_IN}} : par_own ? {8{PAR_OE_IN}} : ser_oe;

   // pull-ups: control bit, off on outputs
   wire [7:0] next_pu = {8{pu_ctrl}} & dir & ~next_oe;

   // port read returns Schmitt-path level on inputs, latch on outputs
   assign port_val = (pin_q & dir) | (lat & ~dir);
   assign ext_in = ext_own ? pin_q : 8'h00;
   assign par_in = par_own ? pin_q : 8'h00;
   // SPI data in from pin 5
   assign sdi = ser_spi && dir[`MBP_SDA_PIN] ? pin_q[`MBP_SDA_PIN] : 1'b0;
   // I2C data in, threshold per module level setting
   assign sda = ser_i2c ? pin_q[`MBP_SDA_PIN] : 1'b1;

   // registered pin drive, inputs after reset
   always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         PIN_OUT <= 8'h00;
         PIN_OE_OUT <= 8'h00;
         PULLUP_EN_OUT <= 8'h00;
         PORT_VAL_OUT <= 8'h00;
         EXT_AD_OUT <= 8'h00;
         PAR_D_OUT <= 8'h00;
         SER_SDI_OUT <= 1'b0;
         SER_SDA_OUT <= 1'b1;
         OWNER_OUT <= MBP_OWN_GPIO;
      end else begin
         PIN_OUT <= next_o;
         PIN_OE_OUT <= next_oe;
         PULLUP_EN_OUT <= next_pu;
         PORT_VAL_OUT <= port_val;
         EXT_AD_OUT <= ext_in;
         PAR_D_OUT <= par_in;
         SER_SDI_OUT <= sdi;
         SER_SDA_OUT <= sda;
         OWNER_OUT <= owner;
      end
   end

   assign LAT_OUT = lat;
   assign DIR_OUT = dir;
   // pull-up bit reads back as written on either package
   assign PU_CTRL_OUT = pu_ctrl;

   ext_drive_a: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      ext_own |=> PIN_OUT == $past(EXT_AD_IN) && PIN_OE_OUT == {8{$past(EXT_OE_IN)}})
      else $error("memory bus drive wrong");
   par_drive_a: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      par_own |=> PIN_OUT == $past(PAR_D_IN) && OWNER_OUT == MBP_OWN_PAR)
      else $error("parallel drive wrong");
   gpio_oe_a: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      owner == MBP_OWN_GPIO |=> PIN_OE_OUT == ~$past(dir))
      else $error("gpio enable wrong");
   pu_out_off_a: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      (PULLUP_EN_OUT & PIN_OE_OUT) == 8'h00)
      else $error("pull-up on output");
   pu_ctrl_a: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      !pu_ctrl |=> PULLUP_EN_OUT == 8'h00)
      else $error("pull-up not gated");
   sdo_pin_a: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      sdo_take && !ext_own |=> PIN_OUT[`MBP_SDO_PIN] == $past(SER_SDO_IN))
      else $error("SPI out wrong");
   sdi_pin_a: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      ser_spi && dir[`MBP_SDA_PIN] |=> SER_SDI_OUT == $past(pin_q[`MBP_SDA_PIN]))
      else $error("SPI in wrong");
   // I2C open-drain pull on pin 5
   sda_drive_a: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      sda_take |=> !PIN_OUT[`MBP_SDA_PIN] && PIN_OE_OUT[`MBP_SDA_PIN] == $past(SER_SDA_OE_IN))
      else $error("I2C drive wrong");
   ext_owner_a: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      ext_own |=> OWNER_OUT == MBP_OWN_EXT)
      else $error("owner priority wrong");
   reset_in_a: assert property (@(posedge REF_CLK_IN)
      $rose(RSTN_IN) |-> DIR_OUT == 8'hFF && PULLUP_EN_OUT == 8'h00)
      else $error("reset state wrong");
endmodule // mbp_port

// ===== shared/mbp_cfg.svh
// Constants for the muxed bidirectional port
`ifndef MBP_CFG_SVH
`define MBP_CFG_SVH
`define MBP_WIDTH 8
`define MBP_EXT_BUS_DISABLE_BIT 7
`define MBP_PU_BIT 7
`define MBP_SDO_PIN 4
`define MBP_SDA_PIN 5
`define MBP_DIR_RESET 8'hFF
`define MBP_LAT_RESET 8'h00
`define MBP_PU_RESET 1'b0
`endif

// ===== shared/mbp_pkg.sv
// Types for the muxed bidirectional port
package mbp_pkg;
   typedef logic [7:0] mbp_byte_t;
   typedef enum logic [1:0] {
      MBP_OWN_EXT,
      MBP_OWN_PAR,
      MBP_OWN_SER,
      MBP_OWN_GPIO
   } mbp_owner_t;
endpackage

// ===== verilog/mbp_sync.sv
// Three-stage pin input synchroniser with agreement filter
module mbp_sync (
   input wire logic clk_in, // Clock
   input wire logic rstn_in, // Async reset, active low
   input wire logic [7:0] d_in, // Raw pin levels
   output logic [7:0] q_out // Filtered level
);
   logic [7:0] s1;
   logic [7:0] s2;
   logic [7:0] s3;
   wire [7:0] agree = ~(s2 ^ s3);
   wire [7:0] next_q = (agree & s3) | (~agree & q_out);
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s1 <= 8'h00;
         s2 <= 8'h00;
         s3 <= 8'h00;
         q_out <= 8'h00;
      end else begin
         s1 <= d_in;
         s2 <= s1;
         s3 <= s2;
         q_out <= next_q;
      end
   end
endmodule // mbp_sync

// ===== verilog/mbp_regs.sv
// Latch, direction and pull-up control storage
`include "mbp_cfg.svh"
module mbp_regs (
   input wire logic clk_in, // Clock
   input wire logic rstn_in, // Async reset, active low
   input wire logic lat_we_in, // Latch write strobe
   input wire logic [7:0] lat_d_in, // Latch write data
   input wire logic dir_we_in, // Direction write strobe
   input wire logic [7:0] dir_d_in, // Direction write data
   input wire logic pu_we_in, // Pull-up control write strobe
   input wire logic pu_d_in, // Pull-up control write data
   output logic [7:0] lat_out, // Output latch
   output logic [7:0] dir_out, // Direction bits
   output logic pu_out // Pull-up control bit
);
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         lat_out <= `MBP_LAT_RESET;
         dir_out <= `MBP_DIR_RESET;
         pu_out <= `MBP_PU_RESET;
      end else begin
         if (lat_we_in) lat_out <= lat_d_in;
         if (dir_we_in) dir_out <= dir_d_in;
         if (pu_we_in) pu_out <= pu_d_in;
      end
   end
endmodule // mbp_regs

// ===== test/mbp_board.sv
// Board-side pin model: device drive, board drivers, pull-ups, floating lines
module mbp_board (
   input wire logic clk_in, // Clock
   input wire logic [7:0] oe_in, // Device drive enables
   input wire logic [7:0] drv_in, // Device drive values
   input wire logic [7:0] pu_in, // Weak pull-up enables
   input wire logic [7:0] brd_en_in, // Board drives line
   input wire logic [7:0] brd_in, // Board drive values
   output logic [7:0] pin_out // Resolved pin levels
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] wobble = 8'h55;
   // Undriven lines toggle so a stale level never passes by luck
   always @(posedge clk_in) wobble <= ~wobble;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_out[i] = oe_in[i] ? drv_in[i] : brd_en_in[i] ? brd_in[i] :
            pu_in[i] ? 1'b1 : wobble[i];
      end
   end
endmodule // mbp_board

// ===== test/mbp_port_tb_top.sv
// Self-checking bench for the muxed bidirectional port
module mbp_port_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import mbp_pkg::*;
   typedef struct {string nm; int sel; mbp_byte_t msk; mbp_byte_t exp;} mbp_note_t;
   mbp_note_t notes[$];
   event noted;
   int errors = 0;
   int samples_checked = 0;
   logic clk = 0;
   logic rstn = 0;
   logic we = 0;
   logic pu_d = 0;
   logic ext_dis = 1, ext_oe = 0, par_sel = 0, par_act = 0, par_oe = 0;
   logic spi = 0, i2c = 0, sdo = 0, sda_oe = 0;
   mbp_byte_t lat_d = 8'h00, dir_d = 8'h00, ext_ad = 8'h00, par_d = 8'h00;
   mbp_byte_t brd = 8'h00, brd_en = 8'h00;
   mbp_byte_t pin_in, pin_out, pin_oe, pu_en, port_val, lat_q, dir_q, ext_q, par_q;
   logic pu_q, sdi_q, sda_q;
   mbp_owner_t owner;
   mbp_byte_t obs [12];
   assign obs = '{pin_oe, pin_out, pu_en, port_val, {6'h00, owner}, ext_q, par_q,
      {7'h00, sdi_q}, {7'h00, sda_q}, lat_q, dir_q, {7'h00, pu_q}};

   mbp_port mbp_port_inst (.REF_CLK_IN(clk), .RSTN_IN(rstn),
      .LAT_WE_IN(we), .LAT_D_IN(lat_d), .DIR_WE_IN(we), .DIR_D_IN(dir_d),
      .PU_WE_IN(we), .PU_D_IN(pu_d), .EXT_BUS_DISABLE_IN(ext_dis),
      .EXT_OE_IN(ext_oe), .EXT_AD_IN(ext_ad), .PAR_SEL_IN(par_sel),
      .PAR_ACTIVE_IN(par_act), .PAR_OE_IN(par_oe), .PAR_D_IN(par_d),
      .SER_SPI_IN(spi), .SER_I2C_IN(i2c), .SER_SDO_IN(sdo), .SER_SDA_OE_IN(sda_oe),
      .SER_SMB_LVL_IN(1'b0), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_OUT(pin_oe),
      .PULLUP_EN_OUT(pu_en), .PORT_VAL_OUT(port_val), .LAT_OUT(lat_q), .DIR_OUT(dir_q),
      .PU_CTRL_OUT(pu_q), .EXT_AD_OUT(ext_q), .PAR_D_OUT(par_q), .SER_SDI_OUT(sdi_q),
      .SER_SDA_OUT(sda_q), .OWNER_OUT(owner));
   mbp_board mbp_board_inst (.clk_in(clk), .oe_in(pin_oe), .drv_in(pin_out),
      .pu_in(pu_en), .brd_en_in(brd_en), .brd_in(brd), .pin_out(pin_in));

   initial begin
      forever #12.5 clk = ~clk;
   end

   task automatic report_and_stop();
      #1;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic note(string nm, int sel, mbp_byte_t msk, mbp_byte_t exp);
      notes.push_back('{nm, sel, msk, exp});
      ->noted;
      #1;
   endtask

   task automatic cyc(int k);
      repeat (k) @(negedge clk);
   endtask

   // All three strobes share one pulse; outputs settle two edges later
   task automatic wr(mbp_byte_t l, mbp_byte_t d, logic p);
      we = 1;
      lat_d = l;
      dir_d = d;
      pu_d = p;
      cyc(1);
      we = 0;
      cyc(1);
   endtask

   initial begin
      mbp_note_t n;
      forever begin
         @(noted);
         while (notes.size() > 0) begin
            n = notes.pop_front();
            samples_checked++;
            if ((obs[n.sel] & n.msk) !== (n.exp & n.msk)) begin
               errors++;
               $display("mismatch %s expected %h seen %h", n.nm, n.exp & n.msk,
                  obs[n.sel] & n.msk);
            end
         end
      end
   end

   initial begin
      repeat (2000) @(posedge clk);
      errors++;
      report_and_stop();
   end

   initial begin
      mbp_byte_t l, d, v;
      void'($urandom(85811));
      cyc(6);
      rstn = 1;
      cyc(1);
      note("dir", 10, 8'hFF, 8'hFF);
      note("oe", 0, 8'hFF, 8'h00);
      note("pullup", 2, 8'hFF, 8'h00);
      note("pu_ctrl", 11, 8'h01, 8'h00);
      note("owner", 4, 8'hFF, 8'h03);
      for (int i = 0; i < 4; i++) begin
         l = $urandom();
         d = $urandom();
         v = $urandom();
         brd_en = d;
         brd = v;
         wr(l, d, i[0]);
         note("lat", 9, 8'hFF, l);
         note("dir_rb", 10, 8'hFF, d);
         note("pu_ctrl", 11, 8'h01, {7'h00, i[0]});
         note("oe", 0, 8'hFF, ~d);
         note("pin", 1, ~d, l);
         note("pullup", 2, 8'hFF, i[0] ? d : 8'h00);
         cyc(6);
         note("port", 3, 8'hFF, (v & d) | (l & ~d));
      end
      // Parallel port also requested, memory bus must still win
      ext_ad = $urandom();
      ext_dis = 0;
      ext_oe = 1;
      par_sel = 1;
      par_act = 1;
      par_oe = 1;
      cyc(2);
      note("owner", 4, 8'hFF, 8'h00);
      note("pin", 1, 8'hFF, ext_ad);
      note("oe", 0, 8'hFF, 8'hFF);
      ext_oe = 0;
      brd_en = 8'hFF;
      brd = v;
      cyc(6);
      note("oe", 0, 8'hFF, 8'h00);
      note("ext_in", 5, 8'hFF, v);
      ext_dis = 1;
      par_d = $urandom();
      spi = 1;
      cyc(2);
      note("owner", 4, 8'hFF, 8'h01);
      note("pin", 1, 8'hFF, par_d);
      note("oe", 0, 8'hFF, 8'hFF);
      par_oe = 0;
      brd = ~v;
      cyc(6);
      note("par_in", 6, 8'hFF, ~v);
      par_sel = 0;
      for (int k = 0; k < 2; k++) begin
         sdo = ~k[0];
         brd = {2'b00, k[0], 5'h00};
         // pin 5 set as input for serial data in
         wr(k[0] ? 8'hFF : 8'h00, 8'h20, 1'b1);
         cyc(6);
         note("owner", 4, 8'hFF, 8'h02);
         note("pin", 1, 8'h10, {3'b000, ~k[0], 4'h0});
         note("sdi", 7, 8'h01, {7'h00, k[0]});
         note("pullup", 2, 8'hFF, 8'h20);
      end
      spi = 0;
      i2c = 1;
      sda_oe = 1;
      cyc(2);
      note("oe", 0, 8'h20, 8'h20);
      note("pin", 1, 8'h20, 8'h00);
      sda_oe = 0;
      brd = 8'h00;
      cyc(6);
      note("oe", 0, 8'h20, 8'h00);
      note("sda", 8, 8'h01, 8'h00);
      // Mid-run reset must bring every pin back to input
      i2c = 0;
      rstn = 0;
      cyc(2);
      note("oe", 0, 8'hFF, 8'h00);
      rstn = 1;
      cyc(1);
      note("dir", 10, 8'hFF, 8'hFF);
      note("pullup", 2, 8'hFF, 8'h00);
      note("owner", 4, 8'hFF, 8'h03);
      report_and_stop();
   end
endmodule // mbp_port_tb_top
